// [logic/serial_isp_command_port.sv]
// Contract
// - data sampled on clock rise
// - output changes on clock fall
// - echo 0x53 during third byte
// - low byte before high, 5 bits
// - page write uses word bits 10:5, 6 bits
// - EEPROM byte write auto-erases first
// - EEPROM page changes loaded bytes only
// - chip erase sets flash, EEPROM and lock bits to 0xFF; fuses keep their values
// - poll returns busy in bit zero
// - load page opcodes 0x40, 0x48
// - read program opcodes 0x20, 0x28
// - EEPROM opcodes A0, C0, C1, C2
// - lock and fuse read pairs
// - lock and fuse write codes
// - signature 0x30, calibration 0x38
// - fuse and lock bits active low
`timescale 1ns/1ps
module serial_isp_command_port #(
    parameter int FLASH_WAIT = isp_pkg::FLASH_WAIT_CYC,
    parameter int EEPROM_WAIT = isp_pkg::EEPROM_WAIT_CYC,
    parameter int ERASE_WAIT = isp_pkg::ERASE_WAIT_CYC,
    parameter int FUSE_WAIT = isp_pkg::FUSE_WAIT_CYC
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic target_reset_n,
    input wire logic sck,
    input wire logic mosi,
    output logic miso,
    output logic miso_oe,
    output logic prog_enabled,
    output logic busy
);
    typedef enum logic [2:0] {
        IDLE, FLASH_PROG, EE_BYTE, EE_PAGE_PROG, ERASING, FUSE_PROG
    } op_t;

    logic [2:0] sck_sync_reg;
    logic [1:0] mosi_sync_reg;
    logic [1:0] rst_sync_reg;
    logic sck_rise, sck_fall, prog_active, miso_bit;
    assign sck_rise = sck_sync_reg[1] && !sck_sync_reg[2];
    assign sck_fall = !sck_sync_reg[1] && sck_sync_reg[2];
    assign prog_active = !rst_sync_reg[1];

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            sck_sync_reg <= 3'h0;
            mosi_sync_reg <= 2'h0;
            rst_sync_reg <= 2'h3;
        end else begin
            sck_sync_reg <= {sck_sync_reg[1:0], sck};
            mosi_sync_reg <= {mosi_sync_reg[0], mosi};
            rst_sync_reg <= {rst_sync_reg[0], target_reset_n};
        end
    end

    isp_link_if link ();

    isp_shifter shifter_i (
        .clock(clock),
        .reset_n(reset_n),
        .prog_active(prog_active),
        .sck_rise(sck_rise),
        .sck_fall(sck_fall),
        .mosi_bit(mosi_sync_reg[1]),
        .miso_bit(miso_bit),
        .link(link)
    );

    logic [7:0] flash_mem [isp_pkg::FLASH_WORDS*2];
    logic [7:0] ee_mem [isp_pkg::EE_BYTES];
    logic [15:0] page_buf [isp_pkg::PAGE_WORDS];
    logic [7:0] ee_buf [isp_pkg::EE_PAGE];
    logic [isp_pkg::EE_PAGE-1:0] ee_loaded_reg;
    logic [7:0] lock_reg, fuse_lo_reg, fuse_hi_reg, fuse_ext_reg;
    logic [7:0] cal_reg;
    // Factory trim, never written over this port
    assign cal_reg = isp_pkg::CAL_RST;
    assign cal_reg_unused = cal_reg;
    logic enabled_reg;
    op_t op_reg;
    logic [31:0] wait_reg;
    logic [5:0] tgt_page_reg;
    logic [isp_pkg::EE_ADDR_W-1:0] tgt_ee_reg;
    logic [7:0] tgt_data_reg;
    logic [1:0] fuse_sel_reg;
    logic [7:0] fuse_val_reg;
    logic [isp_pkg::FL_ADDR_W-1:0] sweep_idx_reg;
    logic [isp_pkg::FL_ADDR_W-1:0] sweep_last;
    logic sweep_on_reg;
    logic sweep_end;
    logic busy_reg;
    logic [1:0] idx_prev_reg;
    logic [7:0] cal_reg_unused;
    logic miso_reg, miso_oe_reg;

    // Whole frame at go; partial views at the reply loads
    logic [7:0] b1, b2, b3, b4, b1_now, b2_now;
    assign b1 = link.frame[31:24];
    assign b2 = link.frame[23:16];
    assign b3 = link.frame[15:8];
    assign b4 = link.frame[7:0];
    assign b1_now = link.frame[15:8];
    assign b2_now = link.frame[7:0];

    logic [isp_pkg::FL_ADDR_W-1:0] word_addr, rd_word;
    assign word_addr = {b2[4:0], b3};
    assign rd_word = {link.frame[12:8], link.frame[7:0]};
    logic [isp_pkg::EE_ADDR_W-1:0] ee_addr, ee_rd_addr;
    assign ee_addr = {b2[0], b3};
    assign ee_rd_addr = {link.frame[8], link.frame[7:0]};

    logic idle, go, start_cmd, is_enable, is_erase, is_fusewr;
    assign idle = (op_reg == IDLE);
    assign go = link.frame_done;
    // program and erase gated by enable
    assign start_cmd = go && enabled_reg && idle;
    assign is_enable = (b1 == isp_pkg::OP_ENABLE)
        && (b2 == isp_pkg::OP_ENABLE_KEY);
    assign is_erase = (b1 == isp_pkg::OP_ENABLE)
        && (b2 == isp_pkg::OP_ERASE_KEY);
    assign is_fusewr = (b1 == isp_pkg::OP_ENABLE) && (
        b2 == isp_pkg::WR_LOCK || b2 == isp_pkg::WR_FUSE_LO ||
        b2 == isp_pkg::WR_FUSE_HI || b2 == isp_pkg::WR_FUSE_EXT);

    // Reply chosen from bytes 1..3 before byte 4 shifts out
    logic [7:0] reply3, reply4;
    assign reply3 = (b1_now == isp_pkg::OP_ENABLE) ? b2_now : 8'h00;
    logic [7:0] hi8, fb1;
    assign hi8 = link.frame[15:8];
    assign fb1 = link.frame[23:16];
    always_comb begin
        reply4 = 8'h00;
        if (fb1 == isp_pkg::OP_POLL) begin
            reply4 = {7'h00, !idle};
        end else if (fb1 == isp_pkg::OP_READ_LO) begin
            reply4 = flash_mem[{rd_word, 1'b0}];
        end else if (fb1 == isp_pkg::OP_READ_HI) begin
            reply4 = flash_mem[{rd_word, 1'b1}];
        end else if (fb1 == isp_pkg::OP_EE_READ) begin
            reply4 = ee_mem[ee_rd_addr];
        // lock and fuse reads, raw active-low bits
        end else if (fb1 == isp_pkg::OP_RD_LOCK_HF) begin
            reply4 = (hi8 == isp_pkg::SEL_HIGH) ? fuse_hi_reg : lock_reg;
        end else if (fb1 == isp_pkg::OP_RD_FUSE_EF) begin
            reply4 = (hi8 == isp_pkg::SEL_HIGH) ? fuse_ext_reg : fuse_lo_reg;
        end else if (fb1 == isp_pkg::OP_SIG) begin
            case (link.frame[1:0])
                2'h0: reply4 = isp_pkg::SIG0;
                2'h1: reply4 = isp_pkg::SIG1;
                2'h2: reply4 = isp_pkg::SIG2;
                default: reply4 = 8'h00;
            endcase
        end else if (fb1 == isp_pkg::OP_CAL) begin
            reply4 = cal_reg;
        end
    end
    assign link.byte3_data = reply3;
    assign link.byte4_data = reply4;
    // Byte index seen at the last fall; a change marks a new byte
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            idx_prev_reg <= 2'h0;
        end else if (!prog_active) begin
            idx_prev_reg <= 2'h0;
        end else if (sck_fall) begin
            idx_prev_reg <= link.byte_index;
        end
    end
    logic new_byte;
    assign new_byte = sck_fall && (link.byte_index != idx_prev_reg);
    // replies load on a fall, never while clock high
    assign link.load3 = new_byte && (link.byte_index == 2'h2);
    assign link.load4 = new_byte && (link.byte_index == 2'h3);

    logic is_load_lo;
    logic is_load_hi;
    logic is_page_wr;
    logic is_ee_wr;
    logic is_ee_load;
    logic is_ee_page;
    assign is_load_lo = (b1 == isp_pkg::OP_LOAD_LO);
    assign is_load_hi = (b1 == isp_pkg::OP_LOAD_HI);
    assign is_page_wr = (b1 == isp_pkg::OP_WRITE_PAGE);
    assign is_ee_wr = (b1 == isp_pkg::OP_EE_WRITE);
    assign is_ee_load = (b1 == isp_pkg::OP_EE_LOAD);
    assign is_ee_page = (b1 == isp_pkg::OP_EE_PAGE);

    logic [1:0] fuse_sel;
    assign fuse_sel = (b2 == isp_pkg::WR_LOCK) ? 2'h0
        : (b2 == isp_pkg::WR_FUSE_LO) ? 2'h1
        : (b2 == isp_pkg::WR_FUSE_HI) ? 2'h2
        : 2'h3;

    logic starts_op;
    assign starts_op = start_cmd && (is_erase || is_page_wr || is_fusewr
        || is_ee_wr || is_ee_page);
    op_t op_next;
    assign op_next = is_erase ? ERASING
        : is_page_wr ? FLASH_PROG
        : is_fusewr ? FUSE_PROG
        : is_ee_wr ? EE_BYTE
        : EE_PAGE_PROG;
    logic [31:0] wait_load;
    assign wait_load = is_erase ? 32'(ERASE_WAIT)
        : is_page_wr ? 32'(FLASH_WAIT)
        : is_fusewr ? 32'(FUSE_WAIT)
        : 32'(EEPROM_WAIT);

    // Entries touched per operation; erase sweeps every flash word
    assign sweep_last = (op_reg == ERASING)
        ? isp_pkg::FL_ADDR_W'(isp_pkg::FLASH_WORDS - 1)
        : (op_reg == FLASH_PROG)
        ? isp_pkg::FL_ADDR_W'(isp_pkg::PAGE_WORDS - 1)
        : (op_reg == EE_PAGE_PROG)
        ? isp_pkg::FL_ADDR_W'(isp_pkg::EE_PAGE - 1)
        : '0;
    assign sweep_end = (sweep_idx_reg == sweep_last);

    // Busy lasts for the longer of the sweep and the timed wait
    logic op_done;
    assign op_done = !idle && (wait_reg == 32'h0) && !sweep_on_reg;

    // enable only by the enable instruction
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            enabled_reg <= 1'b0;
        end else if (!prog_active) begin
            enabled_reg <= 1'b0;
        end else if (go && is_enable) begin
            enabled_reg <= 1'b1;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            op_reg <= IDLE;
            wait_reg <= 32'h0;
        end else begin
            case (op_reg)
                IDLE: begin
                    if (starts_op) begin
                        op_reg <= op_next;
                        wait_reg <= wait_load;
                    end
                end
                default: begin
                    if (op_done) begin
                        op_reg <= IDLE;
                    end else if (wait_reg != 32'h0) begin
                        wait_reg <= wait_reg - 32'h1;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            busy_reg <= 1'b0;
        end else begin
            busy_reg <= !idle;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            sweep_on_reg <= 1'b0;
            sweep_idx_reg <= '0;
        end else if (starts_op) begin
            sweep_on_reg <= 1'b1;
            sweep_idx_reg <= '0;
        end else if (sweep_on_reg) begin
            sweep_on_reg <= !sweep_end;
            sweep_idx_reg <= sweep_idx_reg + 13'h0001;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            tgt_page_reg <= 6'h00;
            tgt_ee_reg <= '0;
            tgt_data_reg <= 8'h00;
            fuse_sel_reg <= 2'h0;
            fuse_val_reg <= 8'h00;
        end else if (starts_op) begin
            // page from word bits 10:5; bits 12:11 dropped
            tgt_page_reg <= word_addr[10:5];
            tgt_ee_reg <= ee_addr;
            tgt_data_reg <= b4;
            fuse_sel_reg <= fuse_sel;
            fuse_val_reg <= b4;
        end
    end

    // Fuses land when the timed write ends
    logic fuse_we;
    assign fuse_we = (op_reg == FUSE_PROG) && op_done;
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            lock_reg <= isp_pkg::LOCK_RST;
            fuse_lo_reg <= isp_pkg::FUSE_LO_RST;
            fuse_hi_reg <= isp_pkg::FUSE_HI_RST;
            fuse_ext_reg <= isp_pkg::FUSE_EXT_RST;
        end else if ((op_reg == ERASING) && op_done) begin
            lock_reg <= isp_pkg::ERASED;
        end else if (fuse_we) begin
            if (fuse_sel_reg == 2'h0) begin
                lock_reg <= fuse_val_reg;
            end else if (fuse_sel_reg == 2'h1) begin
                fuse_lo_reg <= fuse_val_reg;
            end else if (fuse_sel_reg == 2'h2) begin
                fuse_hi_reg <= fuse_val_reg;
            end else begin
                fuse_ext_reg <= fuse_val_reg;
            end
        end
    end

    // word picked by five low bits
    always_ff @(posedge clock) begin
        if (start_cmd && is_load_lo) begin
            page_buf[word_addr[4:0]][7:0] <= b4;
        end
        if (start_cmd && is_load_hi) begin
            page_buf[word_addr[4:0]][15:8] <= b4;
        end
        if (start_cmd && is_ee_load) begin
            ee_buf[b3[1:0]] <= b4;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            ee_loaded_reg <= '0;
        end else if (start_cmd && is_ee_load) begin
            ee_loaded_reg[b3[1:0]] <= 1'b1;
        end else if ((op_reg == EE_PAGE_PROG) && op_done) begin
            ee_loaded_reg <= '0;
        end
    end

    logic flash_we;
    logic ee_we;
    logic [isp_pkg::FL_ADDR_W-1:0] flash_wa;
    logic [15:0] flash_wd;
    logic [isp_pkg::EE_ADDR_W-1:0] ee_wa;
    logic [7:0] ee_wd;
    logic [1:0] ee_slot;
    logic ee_in_erase;
    assign ee_slot = sweep_idx_reg[1:0];
    assign ee_in_erase = (op_reg == ERASING)
        && (sweep_idx_reg < isp_pkg::FL_ADDR_W'(isp_pkg::EE_BYTES));
    assign flash_we = sweep_on_reg
        && (op_reg == ERASING || op_reg == FLASH_PROG);
    assign flash_wa = (op_reg == ERASING) ? sweep_idx_reg
        : {2'b00, tgt_page_reg, sweep_idx_reg[4:0]};
    assign flash_wd = (op_reg == ERASING) ? {2{isp_pkg::ERASED}}
        : page_buf[sweep_idx_reg[4:0]];
    // byte write replaces, no separate erase
    assign ee_we = sweep_on_reg && (ee_in_erase || op_reg == EE_BYTE
        || (op_reg == EE_PAGE_PROG && ee_loaded_reg[ee_slot]));
    assign ee_wa = (op_reg == ERASING) ? sweep_idx_reg[8:0]
        : (op_reg == EE_BYTE) ? tgt_ee_reg
        : {tgt_ee_reg[8:2], ee_slot};
    assign ee_wd = (op_reg == ERASING) ? isp_pkg::ERASED
        : (op_reg == EE_BYTE) ? tgt_data_reg
        : ee_buf[ee_slot];

    always_ff @(posedge clock) begin
        if (flash_we) begin
            flash_mem[{flash_wa, 1'b0}] <= flash_wd[7:0];
            flash_mem[{flash_wa, 1'b1}] <= flash_wd[15:8];
        end
        if (ee_we) begin
            ee_mem[ee_wa] <= ee_wd;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            miso_reg <= 1'b0;
            miso_oe_reg <= 1'b0;
        end else begin
            miso_reg <= miso_bit;
            miso_oe_reg <= prog_active;
        end
    end
    assign miso = miso_reg;
    assign miso_oe = miso_oe_reg;
    assign prog_enabled = enabled_reg;
    assign busy = busy_reg;
endmodule

// [logic/isp_pkg.sv]
package isp_pkg;
    localparam int CLK_MHZ = 200;
    localparam int FLASH_WAIT_US = 4500;
    localparam int EEPROM_WAIT_US = 4000;
    localparam int ERASE_WAIT_US = 4000;
    localparam int FUSE_WAIT_US = 4500;
    localparam int FLASH_WAIT_CYC = FLASH_WAIT_US * CLK_MHZ;
    localparam int EEPROM_WAIT_CYC = EEPROM_WAIT_US * CLK_MHZ;
    localparam int ERASE_WAIT_CYC = ERASE_WAIT_US * CLK_MHZ;
    localparam int FUSE_WAIT_CYC = FUSE_WAIT_US * CLK_MHZ;
    localparam int FLASH_WORDS = 8192;
    localparam int PAGE_WORDS = 32;
    localparam int EE_BYTES = 512;
    localparam int EE_PAGE = 4;
    localparam int EE_ADDR_W = 9;
    localparam int FL_ADDR_W = 13;
    localparam logic [7:0] OP_ENABLE = 8'hAC;
    localparam logic [7:0] OP_ENABLE_KEY = 8'h53;
    localparam logic [7:0] OP_ERASE_KEY = 8'h80;
    localparam logic [7:0] OP_POLL = 8'hF0;
    localparam logic [7:0] OP_LOAD_LO = 8'h40;
    localparam logic [7:0] OP_LOAD_HI = 8'h48;
    localparam logic [7:0] OP_WRITE_PAGE = 8'h4C;
    localparam logic [7:0] OP_READ_LO = 8'h20;
    localparam logic [7:0] OP_READ_HI = 8'h28;
    localparam logic [7:0] OP_EE_READ = 8'hA0;
    localparam logic [7:0] OP_EE_WRITE = 8'hC0;
    localparam logic [7:0] OP_EE_LOAD = 8'hC1;
    localparam logic [7:0] OP_EE_PAGE = 8'hC2;
    localparam logic [7:0] OP_RD_LOCK_HF = 8'h58;
    localparam logic [7:0] OP_RD_FUSE_EF = 8'h50;
    localparam logic [7:0] SEL_HIGH = 8'h08;
    localparam logic [7:0] OP_SIG = 8'h30;
    localparam logic [7:0] OP_CAL = 8'h38;
    localparam logic [7:0] WR_LOCK = 8'hE0;
    localparam logic [7:0] WR_FUSE_LO = 8'hA0;
    localparam logic [7:0] WR_FUSE_HI = 8'hA8;
    localparam logic [7:0] WR_FUSE_EXT = 8'hA4;
    localparam logic [7:0] ERASED = 8'hFF;
    localparam logic [7:0] FUSE_LO_RST = 8'h62;
    localparam logic [7:0] FUSE_HI_RST = 8'hDF;
    localparam logic [7:0] FUSE_EXT_RST = 8'hFF;
    localparam logic [7:0] LOCK_RST = 8'hFF;
    // Arbitrary neutral identity values
    localparam logic [7:0] SIG0 = 8'h11;
    localparam logic [7:0] SIG1 = 8'h22;
    localparam logic [7:0] SIG2 = 8'h33;
    localparam logic [7:0] CAL_RST = 8'h80;
endpackage

// [logic/isp_link_if.sv]
`timescale 1ns/1ps
interface isp_link_if;
    logic [31:0] frame;
    logic frame_done;
    logic [7:0] byte3_data;
    logic [7:0] byte4_data;
    logic load3;
    logic load4;
    logic [1:0] byte_index;
    modport shifter (output frame, frame_done, byte_index,
        input byte3_data, byte4_data, load3, load4);
    modport core (input frame, frame_done, byte_index,
        output byte3_data, byte4_data, load3, load4);
endinterface

// [logic/isp_shifter.sv]
`timescale 1ns/1ps
module isp_shifter (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic prog_active,
    input wire logic sck_rise,
    input wire logic sck_fall,
    input wire logic mosi_bit,
    output logic miso_bit,
    isp_link_if.shifter link
);
    logic [31:0] shift_reg;
    logic [4:0] count_reg;
    logic [7:0] out_reg;
    logic [4:0] count_next;
    assign count_next = count_reg + 5'h01;
    assign link.frame = shift_reg;
    assign link.byte_index = count_reg[4:3];
    assign miso_bit = out_reg[7];
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            shift_reg <= 32'h0;
            count_reg <= 5'h00;
            link.frame_done <= 1'b0;
        end else if (!prog_active) begin
            count_reg <= 5'h00;
            link.frame_done <= 1'b0;
        end else begin
            link.frame_done <= sck_rise && (count_reg == 5'h1F);
            if (sck_rise) begin
                shift_reg <= {shift_reg[30:0], mosi_bit};
                count_reg <= count_next;
            end
        end
    end
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            out_reg <= 8'h00;
        end else if (link.load3) begin
            out_reg <= link.byte3_data;
        end else if (link.load4) begin
            out_reg <= link.byte4_data;
        end else if (sck_fall && count_reg[2:0] != 3'h0) begin
            out_reg <= {out_reg[6:0], 1'b0};
        end
    end
endmodule

// [sim/isp_port_monitor.sv]
`timescale 1ns/1ps
module isp_port_monitor (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic target_reset_n,
    input wire logic sck,
    input wire logic mosi,
    input wire logic miso,
    input wire logic miso_oe,
    input wire logic prog_enabled,
    input wire logic busy
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);
    AST_MISO_ON_FALL: assert property (
        miso_oe && $past(miso_oe) && $changed(miso) |-> !sck)
        else $error("miso moved while sck high");
    AST_BUSY_NEEDS_EN: assert property (busy |-> prog_enabled)
        else $error("busy without programming enabled");
    AST_BUSY_HOLD: assert property ($rose(busy) |-> busy[*8])
        else $error("busy too short");
    // Longest wait plus margin; sweeps run under the wait
    localparam int BUSY_MAX = 1000000;
    int busy_run;
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            busy_run <= 0;
        end else if (busy) begin
            busy_run <= busy_run + 1;
        end else begin
            busy_run <= 0;
        end
    end
    AST_BUSY_END: assert property (busy_run < BUSY_MAX)
        else $error("busy never cleared");
    AST_OE_IN_RESET: assert property (
        target_reset_n[*4] |-> !miso_oe)
        else $error("miso driven outside programming");
    AST_EN_DROP: assert property (
        target_reset_n[*4] |-> !prog_enabled)
        else $error("enable kept after target reset");
    AST_EN_ROSE: assert property (
        $rose(prog_enabled) |-> !target_reset_n)
        else $error("enable outside target reset");
    AST_EN_FELL: assert property ($fell(prog_enabled) |->
        target_reset_n || $past(target_reset_n) ||
        $past(target_reset_n, 2) || $past(target_reset_n, 3))
        else $error("enable lost without target reset");
endmodule
bind serial_isp_command_port isp_port_monitor i_isp_port_monitor (
    .clock, .reset_n, .target_reset_n, .sck, .mosi, .miso,
    .miso_oe, .prog_enabled, .busy);

// [sim/isp_programmer.sv]
`timescale 1ns/1ps
module isp_programmer #(
    parameter int START_WAIT = 200
) (
    input wire logic clock,
    input wire logic miso,
    input wire logic miso_oe,
    output logic target_reset_n,
    output logic sck,
    output logic mosi
);
    logic miso_last;
    logic line;
    // Released line shows the inverse, never a stale bit
    assign line = miso_oe ? miso : ~miso_last;
    always @(posedge clock) begin
        if (miso_oe) begin
            miso_last <= miso;
        end
    end
    // reset and clock low at power-up
    initial begin
        target_reset_n = 1'b0;
        sck = 1'b0;
        mosi = 1'b0;
        miso_last = 1'b0;
    end
    // settle wait, shortened to save run time
    task automatic start();
        repeat (START_WAIT) @(posedge clock);
    endtask
    task automatic pulse_reset();
        @(posedge clock) target_reset_n <= 1'b1;
        repeat (4) @(posedge clock);
        target_reset_n <= 1'b0;
        repeat (START_WAIT) @(posedge clock);
    endtask
    // whole frame, MSB first, slow phases
    task automatic xfer(input logic [31:0] tx, output logic [31:0] rx);
        rx = 32'h00000000;
        for (int i = 31; i >= 0; i--) begin
            @(posedge clock);
            sck <= 1'b0;
            mosi <= tx[i];
            repeat (12) @(posedge clock);
            sck <= 1'b1;
            rx = {rx[30:0], line};
            repeat (12) @(posedge clock);
        end
        @(posedge clock);
        sck <= 1'b0;
    endtask
endmodule

// [sim/serial_isp_command_port_tb_top.sv]
`timescale 1ns/1ps
module serial_isp_command_port_tb_top;
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic target_reset_n, sck, mosi, miso, miso_oe, prog_enabled, busy;
    logic [31:0] rx;
    int fail_count = 0;
    int n_checks = 0;
    int cycles = 0;
    serial_isp_command_port #(.FLASH_WAIT(900), .EEPROM_WAIT(300),
        .ERASE_WAIT(300), .FUSE_WAIT(300)) i_serial_isp_command_port (
        .clock, .reset_n, .target_reset_n, .sck, .mosi, .miso,
        .miso_oe, .prog_enabled, .busy);
    isp_programmer i_isp_programmer (.clock, .miso, .miso_oe,
        .target_reset_n, .sck, .mosi);
    always #2.5 clock = ~clock;
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value at %0t: %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cmd(input logic [31:0] tx);
        i_isp_programmer.xfer(tx, rx);
    endtask
    task automatic rd(input logic [23:0] hdr, input logic [7:0] exp);
        cmd({hdr, 8'h00});
        check(rx[7:0], exp);
    endtask
    task automatic wait_idle();
        for (int k = 0; k < 16; k++) begin
            cmd({isp_pkg::OP_POLL, 24'h000000});
            if (rx[0] === 1'b0) return;
        end
        check(8'h01, 8'h00);
    endtask
    task automatic t_enable();
        cmd({isp_pkg::OP_ENABLE, isp_pkg::OP_ERASE_KEY, 16'h0000});
        repeat (4) @(posedge clock);
        check({7'h00, busy}, 8'h00);
        cmd({isp_pkg::OP_ENABLE, isp_pkg::OP_ENABLE_KEY, 16'h0000});
        check(rx[15:8], 8'h53);
        check({7'h00, prog_enabled}, 8'h01);
        check({7'h00, miso_oe}, 8'h01);
        $display("test enable done");
    endtask
    task automatic t_flash();
        cmd({isp_pkg::OP_LOAD_LO, 16'h0005, 8'h12});
        cmd({isp_pkg::OP_LOAD_HI, 16'h0005, 8'h34});
        cmd({isp_pkg::OP_WRITE_PAGE, 16'h0045, 8'h00});
        cmd({isp_pkg::OP_POLL, 24'h000000});
        check(rx[7:0], 8'h01);
        wait_idle();
        rd({isp_pkg::OP_READ_LO, 16'h0045}, 8'h12);
        rd({isp_pkg::OP_READ_HI, 16'h0045}, 8'h34);
        $display("test flash done");
    endtask
    task automatic t_eeprom();
        cmd({isp_pkg::OP_EE_WRITE, 16'h0007, 8'hA5});
        wait_idle();
        cmd({isp_pkg::OP_EE_WRITE, 16'h0007, 8'h5A});
        wait_idle();
        rd({isp_pkg::OP_EE_READ, 16'h0007}, 8'h5A);
        cmd({isp_pkg::OP_ENABLE, isp_pkg::OP_ERASE_KEY, 16'h0000});
        wait_idle();
        rd({isp_pkg::OP_READ_LO, 16'h0045}, 8'hFF);
        rd({isp_pkg::OP_EE_READ, 16'h0007}, 8'hFF);
        cmd({isp_pkg::OP_EE_LOAD, 16'h0001, 8'h3C});
        cmd({isp_pkg::OP_EE_PAGE, 16'h0004, 8'h00});
        wait_idle();
        rd({isp_pkg::OP_EE_READ, 16'h0004}, 8'hFF);
        rd({isp_pkg::OP_EE_READ, 16'h0005}, 8'h3C);
        $display("test eeprom done");
    endtask
    task automatic t_ids();
        logic [7:0] sig [3];
        sig = '{isp_pkg::SIG0, isp_pkg::SIG1, isp_pkg::SIG2};
        for (int k = 0; k < 3; k++) begin
            rd({isp_pkg::OP_SIG, 8'h00, 8'(k)}, sig[k]);
        end
        rd({isp_pkg::OP_CAL, 16'h0000}, isp_pkg::CAL_RST);
        $display("test ids done");
    endtask
    task automatic t_fuses();
        logic [7:0] wr [4];
        logic [15:0] rs [4];
        logic [7:0] rst [4];
        logic [7:0] val [4];
        wr = '{isp_pkg::WR_LOCK, isp_pkg::WR_FUSE_LO,
            isp_pkg::WR_FUSE_HI, isp_pkg::WR_FUSE_EXT};
        rs = '{16'h5800, 16'h5000, 16'h5808, 16'h5008};
        rst = '{isp_pkg::LOCK_RST, isp_pkg::FUSE_LO_RST,
            isp_pkg::FUSE_HI_RST, isp_pkg::FUSE_EXT_RST};
        val = '{8'hFC, 8'h5A, 8'hD9, 8'hFE};
        for (int k = 0; k < 4; k++) begin
            rd({rs[k], 8'h00}, rst[k]);
            cmd({isp_pkg::OP_ENABLE, wr[k], 8'h00, val[k]});
            wait_idle();
            rd({rs[k], 8'h00}, val[k]);
        end
        $display("test fuses done");
    endtask
    task automatic t_resync();
        i_isp_programmer.pulse_reset();
        check({7'h00, prog_enabled}, 8'h00);
        cmd({isp_pkg::OP_ENABLE, isp_pkg::OP_ENABLE_KEY, 16'h0000});
        check(rx[15:8], 8'h53);
        $display("test resync done");
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    always @(posedge clock) begin
        cycles++;
        if (cycles == 90000) begin
            fail_count++;
            conclude();
        end
    end
    initial begin
        repeat (20) @(posedge clock);
        reset_n <= 1'b1;
        i_isp_programmer.start();
        t_enable();
        t_flash();
        t_eeprom();
        t_ids();
        t_fuses();
        t_resync();
        conclude();
    end
endmodule
